// >>> level_sync.sv
// Three-stage synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/100ps

module level_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Asynchronous input
  input wire logic async_in,
  // Filtered level
  output logic level
);

  typedef struct packed {
    logic stage1;
    logic stage2;
    logic stage3;
    logic level;
  } sync_state_type;

  sync_state_type st_ff;
  sync_state_type nxt_st;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.stage1 = async_in;
    nxt_st.stage2 = st_ff.stage1;
    nxt_st.stage3 = st_ff.stage2;
    if (st_ff.stage2 == st_ff.stage3) begin
      nxt_st.level = st_ff.stage3;
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign level = st_ff.level;

endmodule : level_sync

// >>> reset_cause_flags.sv
// Reset cause flags, watchdog reset pulse and start-up delay sequencer.
`timescale 1ns/100ps

// Function
// R1 - A watchdog time-out produces an internal reset pulse exactly one clock long.
// R2 - The falling edge of that pulse starts the start-up delay counter.
// R3 - A watchdog reset sets the watchdog cause flag at bit 3.
// R4 - Watchdog, brown-out and external flags clear on power-on reset or a written zero.
// R5 - A brown-out reset sets the brown-out cause flag at bit 2.
// R6 - A reset from the external pin sets the external cause flag at bit 1.
// R7 - A power-on reset sets the power-on cause flag at bit 0.
// R8 - The power-on flag clears only by a written zero, never by any reset.
// R9 - Software should read and then clear the cause register early after start-up.
// R10 - Writing one leaves a flag unchanged and unused upper bits read as zero.
module reset_cause_flags (
  // APB clock and power-on reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Reset sources
  input wire logic watchdog_timeout,
  input wire logic brownout_detect,
  input wire logic external_reset_pin,
  // Reset sequencing outputs
  output logic watchdog_reset_pulse,
  output logic startup_delay_active,
  // Interrupt
  output logic irq
);

  typedef struct packed {
    reset_cause_pkg::seq_state_type seq;
    logic [reset_cause_pkg::CNT_W-1:0] count;
    logic wdt_pulse;
    logic [reset_cause_pkg::CAUSE_W-1:0] cause;
    logic [reset_cause_pkg::EVENT_W-1:0] int_status;
    logic [reset_cause_pkg::EVENT_W-1:0] int_enable;
    logic brownout_prev;
    logic external_prev;
    logic [31:0] rdata;
  } state_type;

  state_type st_ff;
  state_type nxt_st;

  logic brownout_level;
  logic external_level;
  logic brownout_rise;
  logic external_rise;
  logic sel_cause;
  logic sel_int_status;
  logic sel_int_clear;
  logic sel_int_enable;
  logic sel_seq_status;
  logic addr_hit;
  logic access_phase;
  logic setup_phase;
  logic wr_lane0;
  logic [reset_cause_pkg::CAUSE_W-1:0] cause_set;
  logic [reset_cause_pkg::CAUSE_W-1:0] cause_clear;
  logic [reset_cause_pkg::EVENT_W-1:0] events;
  logic [reset_cause_pkg::EVENT_W-1:0] int_clear;
  logic [31:0] read_mux;
  logic startup_done;

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  level_sync u_brownout_sync (
    .clk(pclk),
    .rst_n(presetn),
    .async_in(brownout_detect),
    .level(brownout_level)
  );

  level_sync u_external_sync (
    .clk(pclk),
    .rst_n(presetn),
    .async_in(external_reset_pin),
    .level(external_level)
  );

  assign brownout_rise = brownout_level & ~st_ff.brownout_prev;
  assign external_rise = external_level & ~st_ff.external_prev;

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  assign sel_cause = (paddr == reset_cause_pkg::CAUSE_OFFSET);
  assign sel_int_status = (paddr == reset_cause_pkg::INT_STATUS_OFFSET);
  assign sel_int_clear = (paddr == reset_cause_pkg::INT_CLEAR_OFFSET);
  assign sel_int_enable = (paddr == reset_cause_pkg::INT_ENABLE_OFFSET);
  assign sel_seq_status = (paddr == reset_cause_pkg::SEQ_STATUS_OFFSET);
  assign addr_hit = sel_cause | sel_int_status | sel_int_clear |
                    sel_int_enable | sel_seq_status;
  assign setup_phase = psel & ~penable;
  assign access_phase = psel & penable;
  assign wr_lane0 = access_phase & pwrite & pstrb[0] & addr_hit;

  // ----------------------------------------------------------------------
  // Read data selection
  // ----------------------------------------------------------------------
  always_comb begin
    read_mux = 32'h00000000;
    if (sel_cause) begin
      read_mux[reset_cause_pkg::CAUSE_W-1:0] = st_ff.cause; // [R10]
    end else if (sel_int_status) begin
      read_mux[reset_cause_pkg::EVENT_W-1:0] = st_ff.int_status;
    end else if (sel_int_enable) begin
      read_mux[reset_cause_pkg::EVENT_W-1:0] = st_ff.int_enable;
    end else if (sel_seq_status) begin
      read_mux[reset_cause_pkg::SEQ_BUSY_BIT] =
        (st_ff.seq == reset_cause_pkg::SEQ_COUNT);
      read_mux[reset_cause_pkg::SEQ_BROWNOUT_LEVEL_BIT] = brownout_level;
      read_mux[reset_cause_pkg::SEQ_EXTERNAL_LEVEL_BIT] = external_level;
      read_mux[reset_cause_pkg::SEQ_COUNT_LSB +: reset_cause_pkg::CNT_W] =
        st_ff.count;
    end
  end

  // ----------------------------------------------------------------------
  // Flag set and clear terms
  // ----------------------------------------------------------------------
  always_comb begin
    cause_set = '0;
    cause_set[reset_cause_pkg::WATCHDOG_BIT] = nxt_st.wdt_pulse; // [R3]
    cause_set[reset_cause_pkg::BROWNOUT_BIT] = brownout_rise; // [R5]
    cause_set[reset_cause_pkg::EXTERNAL_BIT] = external_rise; // [R6]
    cause_clear = '0;
    int_clear = '0;
    if (wr_lane0 && sel_cause) begin
      // A written zero clears a flag and a written one leaves it alone.
      cause_clear = ~pwdata[reset_cause_pkg::CAUSE_W-1:0]; // [R4] [R8] [R10]
    end
    if (wr_lane0 && sel_int_clear) begin
      int_clear = pwdata[reset_cause_pkg::EVENT_W-1:0];
    end
  end

  always_comb begin
    events = '0;
    events[reset_cause_pkg::EV_WATCHDOG_BIT] = nxt_st.wdt_pulse;
    events[reset_cause_pkg::EV_BROWNOUT_BIT] = brownout_rise;
    events[reset_cause_pkg::EV_EXTERNAL_BIT] = external_rise;
    events[reset_cause_pkg::EV_STARTUP_DONE_BIT] = startup_done;
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    startup_done = 1'b0;

    // A time-out held high yields a one-cycle pulse on every second cycle.
    nxt_st.wdt_pulse = watchdog_timeout & ~st_ff.wdt_pulse; // [R1]

    nxt_st.brownout_prev = brownout_level;
    nxt_st.external_prev = external_level;

    case (st_ff.seq)
      reset_cause_pkg::SEQ_IDLE: begin
        if (st_ff.wdt_pulse) begin
          // The pulse falls in this cycle, so the delay starts now.
          nxt_st.seq = reset_cause_pkg::SEQ_COUNT; // [R2]
          nxt_st.count = reset_cause_pkg::STARTUP_LOAD; // [R2]
        end
      end
      reset_cause_pkg::SEQ_COUNT: begin
        if (st_ff.wdt_pulse) begin
          nxt_st.count = reset_cause_pkg::STARTUP_LOAD; // [R2]
        end else if (st_ff.count == '0) begin
          nxt_st.seq = reset_cause_pkg::SEQ_IDLE;
          startup_done = 1'b1;
        end else begin
          nxt_st.count = st_ff.count - 1'b1;
        end
      end
      default: begin
        nxt_st.seq = reset_cause_pkg::SEQ_IDLE;
        nxt_st.count = '0;
      end
    endcase

    // Set wins over a clear in the same cycle.
    nxt_st.cause = (st_ff.cause & ~cause_clear) | cause_set; // [R4] [R8]
    nxt_st.int_status = (st_ff.int_status & ~int_clear) | events;

    if (wr_lane0 && sel_int_enable) begin
      nxt_st.int_enable = pwdata[reset_cause_pkg::EVENT_W-1:0];
    end

    if (setup_phase && !pwrite) begin
      nxt_st.rdata = read_mux;
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff.seq <= reset_cause_pkg::SEQ_IDLE;
      st_ff.count <= '0;
      st_ff.wdt_pulse <= 1'b0;
      st_ff.cause <= reset_cause_pkg::CAUSE_RESET; // [R7] [R4]
      st_ff.int_status <= reset_cause_pkg::INT_STATUS_RESET;
      st_ff.int_enable <= reset_cause_pkg::INT_ENABLE_RESET;
      st_ff.brownout_prev <= 1'b0;
      st_ff.external_prev <= 1'b0;
      st_ff.rdata <= 32'h00000000;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign prdata = st_ff.rdata;
  assign pready = 1'b1;
  assign pslverr = access_phase & ~addr_hit;
  assign watchdog_reset_pulse = st_ff.wdt_pulse; // [R1]
  assign startup_delay_active = (st_ff.seq == reset_cause_pkg::SEQ_COUNT);
  assign irq = |(st_ff.int_status & st_ff.int_enable);

endmodule : reset_cause_flags

// >>> reset_cause_flags_bench.sv
// Directed bench for the reset cause block.
`timescale 1ns/100ps

module reset_cause_flags_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic watchdog_timeout, brownout_detect, external_reset_pin;
  logic watchdog_reset_pulse, startup_delay_active;
  int n_mismatch = 0;
  int compares = 0;
  int n_pulse = 0;
  int n_active = 0;
  localparam logic [11:0] CA = reset_cause_pkg::CAUSE_OFFSET;
  localparam logic [11:0] IS = reset_cause_pkg::INT_STATUS_OFFSET;
  localparam logic [11:0] IC = reset_cause_pkg::INT_CLEAR_OFFSET;
  localparam logic [11:0] IE = reset_cause_pkg::INT_ENABLE_OFFSET;

  reset_cause_flags i_reset_cause_flags (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .watchdog_timeout(watchdog_timeout), .brownout_detect(brownout_detect),
    .external_reset_pin(external_reset_pin),
    .watchdog_reset_pulse(watchdog_reset_pulse),
    .startup_delay_active(startup_delay_active), .irq(irq)
  );

  // --------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdc

  task automatic report_and_stop;
    if (n_mismatch == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  // --------------------------------------------------------------------
  // Clock, monitor and watchdog
  // --------------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (watchdog_reset_pulse === 1'b1) n_pulse++;
    if (startup_delay_active === 1'b1) n_active++;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    report_and_stop();
  end

  // --------------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, watchdog_timeout} = 4'h0;
    {brownout_detect, external_reset_pin} = 2'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdc(CA, 32'h1);
    apb(1'b1, IE, 32'hF);
    @(posedge pclk);
    watchdog_timeout <= 1'b1;
    @(posedge pclk);
    watchdog_timeout <= 1'b0;
    rdc(CA, 32'h9);
    for (int i = 0; i < 2000 && startup_delay_active !== 1'b0; i++) begin
      @(posedge pclk);
    end
    chk(n_pulse, 32'h1);
    chk(n_active, 32'(reset_cause_pkg::STARTUP_DELAY_CYCLES));
    brownout_detect <= 1'b1;
    repeat (8) @(posedge pclk);
    rdc(CA, 32'hD);
    external_reset_pin <= 1'b1;
    repeat (8) @(posedge pclk);
    rdc(CA, 32'hF);
    rdc(IS, 32'hF);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, CA, 32'hF);
    rdc(CA, 32'hF);
    apb(1'b1, CA, 32'hE);
    rdc(CA, 32'hE);
    apb(1'b1, CA, 32'h7);
    rdc(CA, 32'h6);
    apb(1'b1, CA, 32'h0);
    rdc(CA, 32'h0);
    apb(1'b1, CA, 32'hFFFFFFFF);
    rdc(CA, 32'h0);
    apb(1'b1, IE, 32'h0);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, IE, 32'hF);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, IC, 32'hF);
    rdc(IS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    rdc(12'h020, 32'h0);
    chk({31'h0, err}, 32'h1);
    brownout_detect <= 1'b0;
    external_reset_pin <= 1'b0;
    repeat (8) @(posedge pclk);
    apb(1'b1, CA, 32'h0);
    watchdog_timeout <= 1'b1;
    @(posedge pclk);
    watchdog_timeout <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    chk({31'h0, startup_delay_active}, 32'h0);
    rdc(CA, 32'h1);
    apb(1'b1, CA, 32'h0);
    rdc(CA, 32'h0);
    report_and_stop();
  end
endmodule : reset_cause_flags_bench

// >>> reset_cause_flags_properties.sv
// Concurrent checks on the reset cause block ports.
`timescale 1ns/100ps

module reset_cause_flags_properties (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Reset sources and sequencing
  input wire logic watchdog_timeout,
  input wire logic brownout_detect,
  input wire logic external_reset_pin,
  input wire logic watchdog_reset_pulse,
  input wire logic startup_delay_active,
  input wire logic irq
);
  // --------------------------------------------------------------------
  // Shadow of the watchdog and power-on flags
  // --------------------------------------------------------------------
  logic wd_ff, por_ff, nxt_wd, nxt_por, cw, cr;
  assign cw = psel && penable && pwrite && pready && pstrb[0]
    && paddr == reset_cause_pkg::CAUSE_OFFSET;
  assign cr = psel && !penable && !pwrite
    && paddr == reset_cause_pkg::CAUSE_OFFSET;
  always_comb begin
    nxt_wd = (cw && !pwdata[3]) ? 1'b0 : wd_ff;
    nxt_por = (cw && !pwdata[0]) ? 1'b0 : por_ff;
    if (watchdog_timeout && !watchdog_reset_pulse) begin
      nxt_wd = 1'b1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_ff <= 1'b0;
      por_ff <= 1'b1;
    end else begin
      wd_ff <= nxt_wd;
      por_ff <= nxt_por;
    end
  end
  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_PULSE_ONE: assert property (
    watchdog_reset_pulse |=> !watchdog_reset_pulse)
    else $error("watchdog pulse longer than one cycle");
  AST_PULSE_ON_TIMEOUT: assert property (
    watchdog_timeout && !watchdog_reset_pulse |=> watchdog_reset_pulse)
    else $error("no watchdog pulse after time-out");
  AST_DELAY_START: assert property (
    $fell(watchdog_reset_pulse) |-> startup_delay_active)
    else $error("start-up delay not started at pulse end");
  AST_DELAY_CAUSE: assert property (
    $rose(startup_delay_active) |-> $past(watchdog_reset_pulse))
    else $error("start-up delay started without pulse");
  AST_DELAY_HOLD: assert property (
    $rose(startup_delay_active) |-> startup_delay_active[*8])
    else $error("start-up delay ended too early");
  AST_UPPER_ZERO: assert property (
    cr |=> prdata[31:4] == 28'h0000000)
    else $error("unused cause bits not zero");
  AST_WD_FLAG: assert property (
    cr |=> prdata[3] == $past(wd_ff))
    else $error("watchdog flag wrong");
  AST_POR_FLAG: assert property (
    cr |=> prdata[0] == $past(por_ff))
    else $error("power-on flag wrong");
  cover property ($fell(startup_delay_active));
  cover property (cr ##1 prdata[3]);
  cover property (psel && penable && pslverr);
endmodule : reset_cause_flags_properties

bind reset_cause_flags reset_cause_flags_properties i_props (.*);

// >>> reset_cause_pkg.sv
// Constants and types shared by the reset cause block.
package reset_cause_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] CAUSE_OFFSET = 12'h000;
  localparam logic [11:0] INT_STATUS_OFFSET = 12'h004;
  localparam logic [11:0] INT_CLEAR_OFFSET = 12'h008;
  localparam logic [11:0] INT_ENABLE_OFFSET = 12'h00C;
  localparam logic [11:0] SEQ_STATUS_OFFSET = 12'h010;

  // ----------------------------------------------------------------------
  // Reset cause register fields
  // ----------------------------------------------------------------------
  localparam int CAUSE_W = 4;
  localparam int POWERUP_BIT = 0;
  localparam int EXTERNAL_BIT = 1;
  localparam int BROWNOUT_BIT = 2;
  localparam int WATCHDOG_BIT = 3;
  localparam logic [3:0] CAUSE_RESET = 4'h1;

  // ----------------------------------------------------------------------
  // Interrupt event fields
  // ----------------------------------------------------------------------
  localparam int EVENT_W = 4;
  localparam int EV_WATCHDOG_BIT = 0;
  localparam int EV_BROWNOUT_BIT = 1;
  localparam int EV_EXTERNAL_BIT = 2;
  localparam int EV_STARTUP_DONE_BIT = 3;
  localparam logic [3:0] INT_STATUS_RESET = 4'h0;
  localparam logic [3:0] INT_ENABLE_RESET = 4'h0;

  // ----------------------------------------------------------------------
  // Sequencer status fields
  // ----------------------------------------------------------------------
  localparam int SEQ_BUSY_BIT = 0;
  localparam int SEQ_BROWNOUT_LEVEL_BIT = 1;
  localparam int SEQ_EXTERNAL_LEVEL_BIT = 2;
  localparam int SEQ_COUNT_LSB = 16;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_FREQ_MHZ = 25;
  localparam int STARTUP_DELAY_US = 64;
  localparam int STARTUP_DELAY_CYCLES = STARTUP_DELAY_US * CLK_FREQ_MHZ;
  localparam int CNT_W = 11;
  localparam logic [10:0] STARTUP_LOAD = 11'(STARTUP_DELAY_CYCLES - 1);

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic {SEQ_IDLE, SEQ_COUNT} seq_state_type;

endpackage : reset_cause_pkg
